/* File: hdl/regulator_enable_control.sv */
// Serial-bus command registers and enable logic for the LDOs and step-down converters
//
// Functional notes
// R01 - Fixed LDO on from its pin or bit5
// R02 - Bits 5/6 pick wait-below-300mV or immediate
// R03 - Aux field bits 6:5 select LDO voltage
// R04 - Pin low: bits 5 and 6 enable independently
// R05 - Base part: pin ORed with both bits
// R06 - Decouple bit: selectable LDO ignores pin
// R07 - Derivatives: selectable LDO by register only
// R08 - Buck reference from five-bit first/second code
// R09 - Independent mode per step-down converter
// R10 - Slewing down forces continuous mode
// R11 - Power-on loads all default values
// R12 - Host enables second LDO separately
// R13 - Wait option holds enable until output low
// R14 - Writes act right after data byte accepted
`timescale 1ns/100ps

module regulator_enable_control
  import regulator_enable_control_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2A,  // Arbitrary bus address
  parameter logic [1:0] VARIANT  = VARIANT_BASE
) (
  input  wire logic                          sys_clk,
  input  wire logic                          arst_n,
  input  wire logic                          scl,
  input  wire logic                          sdaIn,
  output      logic                          sdaOut,
  output      logic                          sdaOeN,
  input  wire logic                          ldoEnablePin,
  input  wire logic [1:0]                    ldoOutputLow,
  input  wire logic [NUM_BUCK-1:0]           buckSlewDown,
  output      logic [1:0]                    ldoEnable,
  output      logic [1:0]                    ldoVoltageSel,
  output      logic [NUM_BUCK*CODE_W-1:0]    buckRefCode,
  output      logic [NUM_BUCK*MODE_W-1:0]    buckMode
);

  typedef struct packed {
    bus_state_t                 state;
    logic [3:0]                 cnt;
    logic [7:0]                 shift;
    logic [7:0]                 sub;
    logic                       rw;
    logic                       drive;
    logic                       sclPrev;
    logic                       sdaPrev;
    logic [7:0]                 switcherMode;
    logic [7:0]                 outputEnable;
    logic [7:0]                 startupWait;
    logic [7:0]                 refSelect;
    logic [NUM_BUCK-1:0][7:0]   buckFirst;
    logic [NUM_BUCK-1:0][7:0]   buckSecond;
    logic [7:0]                 ldoAux;
    logic [1:0]                 ldoEn;
    logic [NUM_BUCK*CODE_W-1:0] refCode;
    logic [NUM_BUCK*MODE_W-1:0] mode;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // Register read decode
  function automatic logic [7:0] regRead(input state_t s, input logic [7:0] a);
    logic [7:0] v;
    v = READ_UNMAPPED;
    if (a == OFS_SWITCHER_MODE)  v = s.switcherMode;
    if (a == OFS_OUTPUT_ENABLE)  v = s.outputEnable;
    if (a == OFS_STARTUP_WAIT)   v = s.startupWait;
    if (a == OFS_REF_SELECT)     v = s.refSelect;
    if (a == OFS_LDO_AUX_TARGET) v = s.ldoAux;
    if (a == OFS_ENABLE_STATUS)  v = {6'h00, s.ldoEn};
    for (int b = 0; b < NUM_BUCK; b++) begin
      if (a == 8'(OFS_BUCK_FIRST_0 + 8'(b) * OFS_BUCK_STRIDE))  v = s.buckFirst[b];
      if (a == 8'(OFS_BUCK_SECOND_0 + 8'(b) * OFS_BUCK_STRIDE)) v = s.buckSecond[b];
    end
    return v;
  endfunction : regRead

  logic sclRise;
  logic sclFall;
  logic busStart;
  logic busStop;
  logic [1:0] ldoReq;
  logic [1:0] ldoWait;

  // Bus line events from the previous samples
  assign sclRise  = scl & ~st_r.sclPrev;
  assign sclFall  = ~scl & st_r.sclPrev;
  assign busStart = scl & st_r.sclPrev & st_r.sdaPrev & ~sdaIn;
  assign busStop  = scl & st_r.sclPrev & ~st_r.sdaPrev & sdaIn;

  // Enable requests from pin and register bits
  always_comb begin
    ldoReq[0] = ldoEnablePin | st_r.outputEnable[BIT_FIXED_LDO];  // R01
    if (VARIANT == VARIANT_BASE) begin
      ldoReq[1] = st_r.outputEnable[BIT_SEL_LDO]
                | (ldoEnablePin & ~st_r.ldoAux[BIT_DECOUPLE]);    // R04 R05 R06
    end else begin
      ldoReq[1] = st_r.outputEnable[BIT_SEL_LDO];                 // R07
    end
    for (int i = 0; i < 2; i++) begin
      // Second derivative inverts the wait polarity
      ldoWait[i] = (VARIANT == VARIANT_SECOND) ? st_r.startupWait[BIT_FIXED_LDO + i]
                                               : ~st_r.startupWait[BIT_FIXED_LDO + i];  // R02
    end
  end

  // Next-state logic: bus engine, registers, enables, converter outputs
  always_comb begin
    st_nxt         = st_r;
    st_nxt.sclPrev = scl;
    st_nxt.sdaPrev = sdaIn;

    unique case (st_r.state)
      S_IDLE: begin
        st_nxt.drive = 1'b0;
      end
      S_ADDR, S_SUB, S_WDATA: begin
        if (sclRise) begin
          st_nxt.shift = {st_r.shift[6:0], sdaIn};
          st_nxt.cnt   = st_r.cnt + 4'h1;
        end else if (sclFall && st_r.cnt == BITS_PER_BYTE) begin
          st_nxt.cnt = 4'h0;
          if (st_r.state == S_ADDR) begin
            if (st_r.shift[7:1] == DEV_ADDR) begin
              st_nxt.rw    = st_r.shift[0];
              st_nxt.drive = 1'b1;
              st_nxt.state = S_ACKA;
            end else begin
              st_nxt.state = S_IDLE;
            end
          end else if (st_r.state == S_SUB) begin
            st_nxt.sub   = st_r.shift;
            st_nxt.drive = 1'b1;
            st_nxt.state = S_ACKS;
          end else begin
            // Data byte accepted: commit now
            st_nxt.drive = 1'b1;
            st_nxt.state = S_ACKW;
            if (st_r.sub == OFS_SWITCHER_MODE)  st_nxt.switcherMode = st_r.shift;  // R14
            if (st_r.sub == OFS_OUTPUT_ENABLE)  st_nxt.outputEnable = st_r.shift;  // R14
            if (st_r.sub == OFS_STARTUP_WAIT)   st_nxt.startupWait  = st_r.shift;
            if (st_r.sub == OFS_REF_SELECT)     st_nxt.refSelect    = st_r.shift;
            if (st_r.sub == OFS_LDO_AUX_TARGET) st_nxt.ldoAux       = st_r.shift;
            for (int b = 0; b < NUM_BUCK; b++) begin
              if (st_r.sub == 8'(OFS_BUCK_FIRST_0 + 8'(b) * OFS_BUCK_STRIDE))
                st_nxt.buckFirst[b] = st_r.shift;
              if (st_r.sub == 8'(OFS_BUCK_SECOND_0 + 8'(b) * OFS_BUCK_STRIDE))
                st_nxt.buckSecond[b] = st_r.shift;
            end
          end
        end
      end
      S_ACKA: begin
        if (sclFall) begin
          if (st_r.rw) begin
            st_nxt.shift = regRead(st_r, st_r.sub);
            st_nxt.drive = ~st_nxt.shift[7];  // First read bit goes out at once
            st_nxt.state = S_RDATA;
          end else begin
            st_nxt.drive = 1'b0;
            st_nxt.state = S_SUB;
          end
        end
      end
      S_ACKS, S_ACKW: begin
        if (sclFall) begin
          st_nxt.drive = 1'b0;
          st_nxt.state = S_WDATA;
          if (st_r.state == S_ACKW) st_nxt.sub = st_r.sub + 8'h01;  // Auto-increment
        end
      end
      S_RDATA: begin
        if (sclFall) begin
          if (st_r.cnt == LAST_BIT) begin
            st_nxt.drive = 1'b0;
            st_nxt.state = S_MACK;
          end else begin
            st_nxt.shift = {st_r.shift[6:0], 1'b0};
            st_nxt.drive = ~st_r.shift[6];
            st_nxt.cnt   = st_r.cnt + 4'h1;
          end
        end
      end
      S_MACK: begin
        if (sclRise) begin
          st_nxt.state = sdaIn ? S_IDLE : S_RLOAD;  // Master NACK ends the read
          st_nxt.sub   = st_r.sub + 8'h01;
        end
      end
      S_RLOAD: begin
        if (sclFall) begin
          st_nxt.cnt   = 4'h0;
          st_nxt.shift = regRead(st_r, st_r.sub);
          st_nxt.drive = ~st_nxt.shift[7];
          st_nxt.state = S_RDATA;
        end
      end
    endcase

    // Start and stop override any byte in progress
    if (busStart) begin
      st_nxt.state = S_ADDR;
      st_nxt.cnt   = 4'h0;
      st_nxt.drive = 1'b0;
    end else if (busStop) begin
      st_nxt.state = S_IDLE;
      st_nxt.drive = 1'b0;
    end

    // LDO enables with optional wait for output low
    for (int i = 0; i < 2; i++) begin
      if (!ldoReq[i]) begin
        st_nxt.ldoEn[i] = 1'b0;
      end else if (!st_r.ldoEn[i] && (!ldoWait[i] || ldoOutputLow[i])) begin
        st_nxt.ldoEn[i] = 1'b1;  // R13
      end
    end

    // Converter reference codes and modes
    for (int b = 0; b < NUM_BUCK; b++) begin
      st_nxt.refCode[b*CODE_W +: CODE_W] = st_r.refSelect[b] ? st_r.buckSecond[b][CODE_W-1:0]
                                                             : st_r.buckFirst[b][CODE_W-1:0];  // R08
      st_nxt.mode[b*MODE_W +: MODE_W] = buckSlewDown[b] ? MODE_FORCED                          // R10
                                                        : st_r.switcherMode[b*MODE_W +: MODE_W];  // R09
    end
  end

  // State register with power-on defaults
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r              <= '0;
      st_r.state        <= S_IDLE;
      st_r.sclPrev      <= 1'b1;
      st_r.sdaPrev      <= 1'b1;
      st_r.switcherMode <= RST_SWITCHER_MODE;  // R11
      st_r.outputEnable <= RST_OUTPUT_ENABLE;  // R11
      st_r.startupWait  <= RST_STARTUP_WAIT;   // R11
      st_r.refSelect    <= RST_REF_SELECT;
      st_r.ldoAux       <= RST_LDO_AUX_TARGET; // R11
      st_r.buckFirst    <= {NUM_BUCK{RST_BUCK_TARGET}};   // R08
      st_r.buckSecond   <= {NUM_BUCK{RST_BUCK_TARGET}};
      st_r.refCode      <= {NUM_BUCK{RST_BUCK_TARGET[CODE_W-1:0]}};
      st_r.mode         <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs
  assign sdaOut        = 1'b0;            // Open drain: only pulls low
  assign sdaOeN        = ~st_r.drive;
  assign ldoEnable     = st_r.ldoEn;
  assign ldoVoltageSel = st_r.ldoAux[VSEL_LSB +: 2];  // R03
  assign buckRefCode   = st_r.refCode;
  assign buckMode      = st_r.mode;

endmodule : regulator_enable_control

/* File: hdl/regulator_enable_control_pkg.sv */
// Constants shared by the regulator enable and configuration block
package regulator_enable_control_pkg;

  // Register offsets (subaddresses on the serial bus)
  localparam logic [7:0] OFS_SWITCHER_MODE   = 8'h07;
  localparam logic [7:0] OFS_OUTPUT_ENABLE   = 8'h10;
  localparam logic [7:0] OFS_STARTUP_WAIT    = 8'h12;
  localparam logic [7:0] OFS_REF_SELECT      = 8'h20;
  localparam logic [7:0] OFS_BUCK_FIRST_0    = 8'h23;
  localparam logic [7:0] OFS_BUCK_SECOND_0   = 8'h24;
  localparam logic [7:0] OFS_BUCK_STRIDE     = 8'h02;
  localparam logic [7:0] OFS_LDO_AUX_TARGET  = 8'h2A;
  localparam logic [7:0] OFS_ENABLE_STATUS   = 8'h30;

  // Reset values
  localparam logic [7:0] RST_SWITCHER_MODE   = 8'h00;
  localparam logic [7:0] RST_OUTPUT_ENABLE   = 8'h00;
  localparam logic [7:0] RST_STARTUP_WAIT    = 8'h00;
  localparam logic [7:0] RST_REF_SELECT      = 8'h00;
  localparam logic [7:0] RST_BUCK_TARGET     = 8'h19;
  localparam logic [7:0] RST_LDO_AUX_TARGET  = 8'h00;
  localparam logic [7:0] READ_UNMAPPED       = 8'h00;

  // Field positions, converter count and field widths
  localparam int BIT_FIXED_LDO     = 5;
  localparam int BIT_SEL_LDO       = 6;
  localparam int BIT_DECOUPLE      = 7;
  localparam int VSEL_LSB          = 5;
  localparam int NUM_BUCK          = 3;
  localparam int CODE_W            = 5;
  localparam int MODE_W            = 2;

  // Switcher operating modes
  localparam logic [1:0] MODE_PULSE_SKIP = 2'h0;
  localparam logic [1:0] MODE_BURST      = 2'h1;
  localparam logic [1:0] MODE_FORCED     = 2'h2;

  // Selectable LDO voltage codes on the base part
  localparam logic [1:0] VSEL_2V8 = 2'h0;
  localparam logic [1:0] VSEL_2V5 = 2'h1;
  localparam logic [1:0] VSEL_1V8 = 2'h2;
  localparam logic [1:0] VSEL_3V3 = 2'h3;

  // Part variants
  localparam logic [1:0] VARIANT_BASE   = 2'h0;
  localparam logic [1:0] VARIANT_FIRST  = 2'h1;
  localparam logic [1:0] VARIANT_SECOND = 2'h2;

  // Serial bus framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_BIT      = 4'h7;

  typedef enum logic [9:0] {
    S_IDLE  = 10'h001,
    S_ADDR  = 10'h002,
    S_ACKA  = 10'h004,
    S_SUB   = 10'h008,
    S_ACKS  = 10'h010,
    S_WDATA = 10'h020,
    S_ACKW  = 10'h040,
    S_RDATA = 10'h080,
    S_MACK  = 10'h100,
    S_RLOAD = 10'h200
  } bus_state_t;

endpackage : regulator_enable_control_pkg

/* File: verification/regulator_enable_control_asserts.sv */
// Port assertions for the regulator enable block
`timescale 1ns/100ps
module regulator_enable_control_asserts
  import regulator_enable_control_pkg::*;
(
  input wire logic                       sys_clk,
  input wire logic                       arst_n,
  input wire logic                       scl,
  input wire logic                       sdaOeN,
  input wire logic                       ldoEnablePin,
  input wire logic [1:0]                 ldoOutputLow,
  input wire logic [NUM_BUCK-1:0]        buckSlewDown,
  input wire logic [1:0]                 ldoEnable,
  input wire logic [1:0]                 ldoVoltageSel,
  input wire logic [NUM_BUCK*CODE_W-1:0] buckRefCode,
  input wire logic [NUM_BUCK*MODE_W-1:0] buckMode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // Bus clock high for a while, so no byte is landing
  sequence s_quiet; scl [*4]; endsequence
  // Inputs behind the outputs unchanged over two samples
  sequence s_pins;
    $past(ldoEnablePin) == $past(ldoEnablePin, 2) && $past(ldoOutputLow) == $past(ldoOutputLow, 2);
  endsequence
  sequence s_slew; $past(buckSlewDown) == $past(buckSlewDown, 2); endsequence
  property p_reset_vals; $rose(arst_n) |-> ldoEnable == 2'h0 && ldoVoltageSel == 2'h0 && buckMode == 6'h0 && sdaOeN
    && buckRefCode == {NUM_BUCK{RST_BUCK_TARGET[4:0]}}; endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("outputs off reset values");
  property p_fixed_pin; ldoEnablePin && ldoOutputLow[0] |=> ldoEnable[0]; endproperty
  a_fixed_pin: assert property (p_fixed_pin) else $error("fixed LDO not on from pin");
  property p_ack_start; $fell(sdaOeN) |-> !$past(scl); endproperty
  a_ack_start: assert property (p_ack_start) else $error("data driven outside clock low");
  property p_ack_hold; !sdaOeN && scl |=> !sdaOeN; endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("data released while clock high");
  property p_cfg_quiet; s_quiet |-> $stable(ldoVoltageSel) && $stable(buckRefCode); endproperty
  a_cfg_quiet: assert property (p_cfg_quiet) else $error("setting moved without a write");
  property p_mode_quiet; s_quiet ##0 s_slew |-> $stable(buckMode); endproperty
  a_mode_quiet: assert property (p_mode_quiet) else $error("mode moved without cause");
  property p_en_quiet; s_quiet ##0 s_pins |-> $stable(ldoEnable); endproperty
  a_en_quiet: assert property (p_en_quiet) else $error("enable moved without cause");
  // Slewing down forces continuous mode on that converter
  for (genvar b = 0; b < NUM_BUCK; b++) begin : g_slew
    property p_slew; buckSlewDown[b] |=> buckMode[2*b +: 2] == MODE_FORCED; endproperty
    a_slew: assert property (p_slew) else $error("mode not forced on slew");
  end
endmodule : regulator_enable_control_asserts
bind regulator_enable_control regulator_enable_control_asserts regulator_enable_control_asserts_inst (
  .sys_clk(sys_clk), .arst_n(arst_n), .scl(scl), .sdaOeN(sdaOeN), .ldoEnablePin(ldoEnablePin),
  .ldoOutputLow(ldoOutputLow), .buckSlewDown(buckSlewDown), .ldoEnable(ldoEnable), .ldoVoltageSel(ldoVoltageSel),
  .buckRefCode(buckRefCode), .buckMode(buckMode));

/* File: verification/bus_host.sv */
// Host model: serial bus master for register access
`timescale 1ns/100ps
module bus_host (
  input  wire logic sys_clk,
  input  wire logic sdaLine,
  output      logic scl,
  output      logic sdaDrv
);
  localparam logic [6:0] ADDR = 7'h2A;  // Device default address
  int nacks = 0;
  initial {scl, sdaDrv} = 2'h3;
  // Third of a bit time
  task automatic tick;
    repeat (4) @(posedge sys_clk);
  endtask : tick
  // One bit; data moves only while the bus clock is low
  task automatic bit_x(input logic b, output logic r);
    sdaDrv <= b;
    tick();
    scl <= 1'b1;
    tick();
    r = sdaLine;
    scl <= 1'b0;
    tick();
  endtask : bit_x
  // Start (also repeated) or stop condition
  task automatic frame(input logic start);
    sdaDrv <= start;
    tick();
    scl <= 1'b1;
    tick();
    sdaDrv <= ~start;
    tick();
    scl <= ~start;
    tick();
  endtask : frame
  // Byte, then a released acknowledge bit; a missing device ack is counted
  task automatic xfer(input logic [7:0] d, input logic devAck, output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(1'b1, a);
    if (devAck && a !== 1'b0) nacks++;  // An unknown line counts as a missing ack
  endtask : xfer
  task automatic write_reg(input logic [7:0] sub, input logic [7:0] data);
    logic [7:0] q;
    frame(1'b1);
    xfer({ADDR, 1'b0}, 1'b1, q);
    xfer(sub, 1'b1, q);
    xfer(data, 1'b1, q);
    frame(1'b0);
  endtask : write_reg
  // Read ends with a master no-ack
  task automatic read_reg(input logic [7:0] sub, output logic [7:0] data);
    logic [7:0] q;
    frame(1'b1);
    xfer({ADDR, 1'b0}, 1'b1, q);
    xfer(sub, 1'b1, q);
    frame(1'b1);
    xfer({ADDR, 1'b1}, 1'b1, q);
    xfer(8'hFF, 1'b0, data);
    frame(1'b0);
  endtask : read_reg
endmodule : bus_host

/* File: verification/testbench.sv */
// Self-checking bench for the regulator enable block
`timescale 1ns/100ps
module testbench;
  import regulator_enable_control_pkg::*;
  logic        sys_clk = 1'b0, arst_n = 1'b0, ldoEnablePin = 1'b0, scl, sdaDrv, sdaLine, sdaOut, sdaOeN;
  logic [1:0]  ldoOutputLow = 2'h0, ldoEnable, ldoVoltageSel;
  logic [2:0]  buckSlewDown = 3'h0, sl;
  logic [14:0] buckRefCode;
  logic [5:0]  buckMode, mw;
  logic [7:0]  rd, oe;
  logic [4:0]  t1 [3], t2 [3];
  logic [7:0]  offs [6] = '{OFS_OUTPUT_ENABLE, OFS_STARTUP_WAIT, OFS_LDO_AUX_TARGET, OFS_BUCK_FIRST_0,
                            OFS_BUCK_SECOND_0, 8'h55};
  int          fails = 0, n_compared = 0;
  always #5 sys_clk = ~sys_clk;
  assign sdaLine = sdaDrv & (sdaOeN | sdaOut);  // Open drain with pull-up
  regulator_enable_control regulator_enable_control_inst (.sys_clk(sys_clk), .arst_n(arst_n), .scl(scl),
    .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .ldoEnablePin(ldoEnablePin), .ldoOutputLow(ldoOutputLow),
    .buckSlewDown(buckSlewDown), .ldoEnable(ldoEnable), .ldoVoltageSel(ldoVoltageSel),
    .buckRefCode(buckRefCode), .buckMode(buckMode));
  bus_host bus_host_inst (.sys_clk(sys_clk), .sdaLine(sdaLine), .scl(scl), .sdaDrv(sdaDrv));
  // Value compare
  task automatic chk(input string nm, input logic [14:0] e, input logic [14:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Expected enables: bit0 fixed LDO, bit1 selectable LDO
  function automatic logic [1:0] exp_en(input logic pin, input logic [7:0] o, input logic dec);
    return {o[BIT_SEL_LDO] | (pin & ~dec), o[BIT_FIXED_LDO] | pin};
  endfunction : exp_en
  function automatic logic [5:0] exp_mode(input logic [5:0] m, input logic [2:0] s);
    for (int b = 0; b < NUM_BUCK; b++) if (s[b]) m[2*b +: 2] = MODE_FORCED;
    return m;
  endfunction : exp_mode
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  // Hang guard
  initial begin
    repeat (90000) @(posedge sys_clk);
    fails++;
    wrap_up();
  end
  // Main sequence
  initial begin
    void'($urandom(32'h95A6));
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk("ref", {3{RST_BUCK_TARGET[4:0]}}, buckRefCode);
    for (int i = 0; i < 6; i++) begin
      bus_host_inst.read_reg(offs[i], rd);
      chk("reg", i == 5 ? 15'(READ_UNMAPPED) : i > 2 ? 15'(RST_BUCK_TARGET) : 15'h0, 15'(rd));
    end
    $display("test power-on done");
    for (int c = 0; c < 4; c++) begin
      bus_host_inst.write_reg(OFS_LDO_AUX_TARGET, 8'(c) << VSEL_LSB);
      chk("volt", 15'(c), 15'(ldoVoltageSel));
    end
    for (int b = 0; b < NUM_BUCK; b++) begin
      t1[b] = b ? 5'($urandom) : 5'h1F;
      t2[b] = b ? 5'($urandom) : 5'h00;
      bus_host_inst.write_reg(OFS_BUCK_FIRST_0 + 8'(b) * OFS_BUCK_STRIDE, {3'h0, t1[b]});
      bus_host_inst.write_reg(OFS_BUCK_SECOND_0 + 8'(b) * OFS_BUCK_STRIDE, {3'h0, t2[b]});
    end
    chk("ref", {t1[2], t1[1], t1[0]}, buckRefCode);
    bus_host_inst.write_reg(OFS_REF_SELECT, 8'h07);
    chk("ref", {t2[2], t2[1], t2[0]}, buckRefCode);
    $display("test voltage codes done");
    for (int m = 0; m < 3; m++) begin
      for (int b = 0; b < NUM_BUCK; b++) mw[2*b +: 2] = 2'((m + b) % 3);
      bus_host_inst.write_reg(OFS_SWITCHER_MODE, {2'h0, mw});
      chk("mode", 15'(mw), 15'(buckMode));
      sl = 3'($urandom_range(1, 7));
      buckSlewDown <= sl;
      repeat (3) @(posedge sys_clk);
      chk("mode", 15'(exp_mode(mw, sl)), 15'(buckMode));
      buckSlewDown <= 3'h0;
      repeat (3) @(posedge sys_clk);
      chk("mode", 15'(mw), 15'(buckMode));
    end
    $display("test modes done");
    bus_host_inst.write_reg(OFS_STARTUP_WAIT, 8'h60);
    for (int k = 0; k < 16; k++) begin
      oe = {1'b0, k[2], k[1], 5'($urandom)};
      bus_host_inst.write_reg(OFS_OUTPUT_ENABLE, oe);
      bus_host_inst.write_reg(OFS_LDO_AUX_TARGET, {k[3], 2'($urandom), 5'h00});
      ldoEnablePin <= k[0];
      repeat (3) @(posedge sys_clk);
      chk("enable", 15'(exp_en(k[0], oe, k[3])), 15'(ldoEnable));
    end
    bus_host_inst.read_reg(OFS_OUTPUT_ENABLE, rd);
    chk("reg", 15'(oe), 15'(rd));
    ldoEnablePin <= 1'b0;
    bus_host_inst.write_reg(OFS_OUTPUT_ENABLE, 8'h00);
    bus_host_inst.write_reg(OFS_STARTUP_WAIT, 8'h00);
    bus_host_inst.write_reg(OFS_LDO_AUX_TARGET, 8'h00);
    ldoEnablePin <= 1'b1;
    repeat (20) @(posedge sys_clk);
    chk("enable", 15'h0, 15'(ldoEnable));
    ldoOutputLow <= 2'h3;
    repeat (3) @(posedge sys_clk);
    chk("enable", 15'h3, 15'(ldoEnable));
    bus_host_inst.read_reg(OFS_ENABLE_STATUS, rd);
    chk("status", 15'h3, 15'(rd));
    chk("nacks", 15'h0, 15'(bus_host_inst.nacks));
    $display("test enables done");
    wrap_up();
  end
endmodule : testbench
